// *** design/cl_regs.svh ***
// Constants for the half-bridge current limit logic
`ifndef CL_REGS_SVH
`define CL_REGS_SVH
`define CLK_MHZ 100
`define BLANK_NS 200
`define BLANK_CYC ((`BLANK_NS * `CLK_MHZ + 999) / 1000)
`define RAMP_W 8
`define NEG_TRIP_COUNT 2
`define NEG_WINDOW_PERIODS 4
`define SLOPE_W 8
`define ILIM_W 8
`endif

// *** design/cl_pkg.sv ***
// Types shared by the current limit logic
package cl_pkg;
  typedef enum logic [1:0] {PH_IDLE, PH_LOW, PH_HIGH} phase_t;
endpackage : cl_pkg

// *** design/sync3.sv ***
// Three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/1ps
module sync3
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic d,
  output logic q
);
  logic s1;
  logic s2;
  logic s3;
  // Stage one feeds only stage two; output moves when stages two and three agree
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      q <= 1'b0;
    end
    else
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        q <= s3;
    end
  end
endmodule : sync3

// *** design/half_bridge_current_limit_logic.sv ***
// Cycle-by-cycle current limit, pulse matching and reverse limit counting
`timescale 1ns/1ps
`include "cl_regs.svh"
module half_bridge_current_limit_logic
  import cl_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic OSC_TICK,
  input wire logic LOW_REQ,
  input wire logic HIGH_REQ,
  input wire logic [`RAMP_W-1:0] RAMP,
  input wire logic [`ILIM_W-1:0] ILIM_REF,
  input wire logic POS_COMP,
  input wire logic NEG_COMP,
  output logic LOW_SIDE_GATE,
  output logic HIGH_SIDE_GATE,
  output logic LIMIT_FLAG,
  output logic CYCLE_BY_CYCLE_LIMIT,
  output logic HICCUP_RESTART_TIMER_EN,
  output logic RECTIFIER_SOFTSTART_CLAMP,
  output logic SYNCHRONOUS_RECTIFIER_SYNC,
  output logic [`SLOPE_W-1:0] SLOPE_RAMP,
  output logic [`ILIM_W-1:0] NEG_THRESHOLD
);
  // ****************************************
  // Comparator synchronisers
  // ****************************************
  logic pos_s;
  logic neg_s;
  sync3 u_sync_pos (.CLK(CLK), .RSTN(RSTN), .d(POS_COMP), .q(pos_s));
  sync3 u_sync_neg (.CLK(CLK), .RSTN(RSTN), .d(NEG_COMP), .q(neg_s));

  // ****************************************
  // Phase and blanking
  // ****************************************
  phase_t phase;
  phase_t next_phase;
  logic [7:0] blank_cnt;
  logic [`RAMP_W-1:0] held_ramp;
  logic match_pending;
  logic match_active;
  logic flag_d;
  logic [1:0] neg_cnt;
  logic [2:0] win_cnt;
  logic [1:0] win_events;
  logic clamp;
  logic [`SLOPE_W-1:0] slope;
  logic neg_seen;

  localparam logic [7:0] BLANK_CYCLES = 8'(`BLANK_CYC);
  wire blank_done = (blank_cnt == BLANK_CYCLES);
  // comparators count only once blanking has expired
  wire pos_hit = (phase == PH_LOW) && blank_done && pos_s;
  // reverse trip seen in any unblanked cycle of the low phase
  wire neg_hit = (phase == PH_LOW) && blank_done && neg_s;
  // matched high-side pulse ends when ramp passes the held value
  wire match_end = match_active && (RAMP > held_ramp);
  // one reverse event per low pulse, taken in the first unblanked cycle that sees the trip
  wire neg_event = neg_hit && !neg_seen;
  // a pending matched pulse owns the next half period, so no new low pulse
  wire low_start = LOW_REQ && !match_pending;
  // matched pulse starts once the cut low half period is released
  wire high_start = HIGH_REQ || (match_pending && !LOW_REQ);
  // window spans four switching periods of two oscillator ticks each
  localparam logic [2:0] WIN_LAST = 3'(2 * `NEG_WINDOW_PERIODS - 1);
  wire window_end = OSC_TICK && (win_cnt == WIN_LAST);
  wire [1:0] events_now = win_events + {1'b0, neg_event};
  wire window_short = window_end && (events_now < 2'(`NEG_TRIP_COUNT)) && !clamp;

  // Phase sequencing from the modulator requests
  always_comb
  begin
    next_phase = phase;
    unique case (phase)
      PH_IDLE:
        if (low_start)
          next_phase = PH_LOW;
        else if (high_start)
          next_phase = PH_HIGH;
      // positive trip ends the low-side pulse immediately
      PH_LOW:
        if (!LOW_REQ || pos_hit)
          next_phase = PH_IDLE;
      PH_HIGH:
        if (match_end || (!match_active && !HIGH_REQ))
          next_phase = PH_IDLE;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      phase <= PH_IDLE;
    else
      phase <= next_phase;
  end

  // Blanking counter restarts at each low-side turn-on
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      blank_cnt <= 8'h00;
    else if (phase != PH_LOW)
      blank_cnt <= 8'h00;
    else if (!blank_done)
      blank_cnt <= blank_cnt + 8'h01;
  end

  // Marks the reverse event of this pulse, so a long trip is not counted twice
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      neg_seen <= 1'b0;
    else if (phase != PH_LOW)
      neg_seen <= 1'b0;
    else if (neg_hit)
      neg_seen <= 1'b1;
  end

  // ****************************************
  // Pulse matching
  // ****************************************
  // flag rises on the positive trip and holds until the matched pulse ends
  // matched pulse held regardless of current during the high side
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      flag_d <= 1'b0;
      held_ramp <= 8'h00;
      match_pending <= 1'b0;
      match_active <= 1'b0;
    end
    else
    begin
      if (pos_hit && !flag_d)
      begin
        flag_d <= 1'b1;
        held_ramp <= RAMP;
        match_pending <= 1'b1;
      end
      else if (match_end)
      begin
        flag_d <= 1'b0;
        match_active <= 1'b0;
      end
      if (match_pending && next_phase == PH_HIGH)
      begin
        match_pending <= 1'b0;
        match_active <= 1'b1;
      end
    end
  end

  // ****************************************
  // Reverse limit counting
  // ****************************************
  // four-period window; fewer than two events clears the count unless clamped
  // two events clamp the rectifier softstart; clamp is sticky
  // Trade-off: clamp release is left to the softstart path outside
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      neg_cnt <= 2'b00;
      win_cnt <= 3'b000;
      win_events <= 2'b00;
      clamp <= 1'b0;
    end
    else
    begin
      // An event on the closing tick still counts toward the closing window
      if (window_short)
        neg_cnt <= 2'b00;
      else if (neg_event && neg_cnt != 2'(`NEG_TRIP_COUNT))
        neg_cnt <= neg_cnt + 2'b01;
      if (window_end)
        win_events <= 2'b00;
      else if (neg_event && win_events != 2'(`NEG_TRIP_COUNT))
        win_events <= win_events + 2'b01;
      if (window_end)
        win_cnt <= 3'b000;
      else if (OSC_TICK)
        win_cnt <= win_cnt + 3'b001;
      if (neg_cnt == 2'(`NEG_TRIP_COUNT))
        clamp <= 1'b1;
    end
  end

  // ****************************************
  // Slope ramp and thresholds
  // ****************************************
  // sawtooth restarts each oscillator period
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      slope <= 8'h00;
    else if (OSC_TICK)
      slope <= 8'h00;
    else if (slope != 8'hFF)
      slope <= slope + 8'h01;
  end

  // Registered outputs keep data glitch-free toward the drivers
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
      NEG_THRESHOLD <= 8'h00;
    else
      // reverse threshold is half the positive reference
      NEG_THRESHOLD <= ILIM_REF >> 1;
  end

  assign LOW_SIDE_GATE = (phase == PH_LOW);
  assign HIGH_SIDE_GATE = (phase == PH_HIGH);
  assign LIMIT_FLAG = flag_d;
  assign CYCLE_BY_CYCLE_LIMIT = flag_d;
  assign HICCUP_RESTART_TIMER_EN = flag_d;
  assign RECTIFIER_SOFTSTART_CLAMP = clamp;
  assign SYNCHRONOUS_RECTIFIER_SYNC = clamp;
  assign SLOPE_RAMP = slope;

  // ****************************************
  // Checks
  // ****************************************
  chk_blank_gate: assert property (@(posedge CLK) disable iff (!RSTN)
    (phase == PH_LOW && !blank_done && LOW_REQ) |=> LOW_SIDE_GATE)
    else $error("low side cut during blanking");
  chk_pos_cut: assert property (@(posedge CLK) disable iff (!RSTN)
    pos_hit |=> !LOW_SIDE_GATE)
    else $error("low side not cut on trip");
  chk_flag_rise: assert property (@(posedge CLK) disable iff (!RSTN)
    (pos_hit && !flag_d) |=> LIMIT_FLAG)
    else $error("flag not raised");
  chk_ramp_hold: assert property (@(posedge CLK) disable iff (!RSTN)
    $rose(flag_d) |-> held_ramp == $past(RAMP))
    else $error("ramp not captured");
  chk_match_end: assert property (@(posedge CLK) disable iff (!RSTN)
    (phase == PH_HIGH && match_end) |=> !HIGH_SIDE_GATE)
    else $error("matched pulse not ended");
  chk_hiccup_en: assert property (@(posedge CLK) disable iff (!RSTN)
    (match_pending || match_active) |-> HICCUP_RESTART_TIMER_EN)
    else $error("hiccup enable missing");
  chk_clamp_set: assert property (@(posedge CLK) disable iff (!RSTN)
    (neg_cnt == 2'd2) |=> RECTIFIER_SOFTSTART_CLAMP && SYNCHRONOUS_RECTIFIER_SYNC)
    else $error("clamp not set");
  chk_slope_zero: assert property (@(posedge CLK) disable iff (!RSTN)
    OSC_TICK |=> SLOPE_RAMP == 8'h00)
    else $error("slope not restarted");
  chk_neg_half: assert property (@(posedge CLK) disable iff (!RSTN)
    RSTN |=> NEG_THRESHOLD == ($past(ILIM_REF) >> 1))
    else $error("reverse threshold wrong");
  cov_limit: cover property (@(posedge CLK) disable iff (!RSTN) $rose(LIMIT_FLAG));
  cov_match: cover property (@(posedge CLK) disable iff (!RSTN) match_end);
  cov_clamp: cover property (@(posedge CLK) disable iff (!RSTN) $rose(clamp));
  cov_window: cover property (@(posedge CLK) disable iff (!RSTN) window_short && neg_cnt != 2'b00);
endmodule : half_bridge_current_limit_logic

// *** verif/stage_model.sv ***
// Power stage sense model driving the two comparator levels
`timescale 1ns/1ps
`include "cl_regs.svh"
module stage_model
(
  input wire logic clk,
  input wire logic gate,
  input wire logic pos_en,
  input wire logic neg_en,
  output logic pos_comp,
  output logic neg_comp
);
  int on_cyc;
  // Count low-side on time; reverse current only exists early in the pulse
  always @(posedge clk)
  begin
    on_cyc <= gate ? on_cyc + 1 : 0;
  end
  // Sense current flows only while the low side conducts
  assign pos_comp = gate && pos_en;
  // Reverse trip fades just before blanking ends; only a prompt look catches it
  assign neg_comp = gate && neg_en && on_cyc < `BLANK_CYC - 2;
endmodule : stage_model

// *** verif/test_half_bridge_current_limit_logic.sv ***
// Self-checking bench for the current limit logic
`timescale 1ns/1ps
`include "cl_regs.svh"
module test_half_bridge_current_limit_logic;
  logic clk = 0;
  logic rstn = 0;
  logic osc = 0;
  logic lreq = 0;
  logic hreq = 0;
  logic pos_en = 0;
  logic neg_en = 0;
  logic [7:0] ramp = 0;
  logic [7:0] ilim = 0;
  logic [7:0] v;
  logic [31:0] seed = 32'h7834_ab81;
  logic pos, neg, lg, hg, flg, cbc, hic, clamp, srs;
  logic [7:0] slope, nthr;
  int fail_count, n_compared, w;
  half_bridge_current_limit_logic half_bridge_current_limit_logic_inst (.CLK(clk),
    .RSTN(rstn), .OSC_TICK(osc), .LOW_REQ(lreq), .HIGH_REQ(hreq), .RAMP(ramp),
    .ILIM_REF(ilim), .POS_COMP(pos), .NEG_COMP(neg), .LOW_SIDE_GATE(lg),
    .HIGH_SIDE_GATE(hg), .LIMIT_FLAG(flg), .CYCLE_BY_CYCLE_LIMIT(cbc),
    .HICCUP_RESTART_TIMER_EN(hic), .RECTIFIER_SOFTSTART_CLAMP(clamp),
    .SYNCHRONOUS_RECTIFIER_SYNC(srs), .SLOPE_RAMP(slope), .NEG_THRESHOLD(nthr));
  stage_model stage_model_inst (.clk(clk), .gate(lg), .pos_en(pos_en),
    .neg_en(neg_en), .pos_comp(pos), .neg_comp(neg));
  // 100 MHz clock
  always #5 clk = ~clk;
  // Ramp climbs only in the high phase, so the matched width is the held value plus two cycles
  always @(posedge clk)
  begin
    if (hg === 1'b1)
      ramp <= ramp + 8'h01;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e)
    begin
      fail_count++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  // Bounded wait for a gate level; a hang counts as a mismatch
  task automatic wait_on(input bit hi, input logic lv);
    w = 0;
    while ((hi ? hg : lg) !== lv && w < 300)
    begin
      @(posedge clk);
      w++;
    end
    if (w == 300)
    begin
      fail_count++;
      report_and_stop();
    end
  endtask : wait_on
  // One switching period with a tick per half; reverse trip optional
  task automatic period(input logic n);
    neg_en <= n;
    lreq <= 1;
    osc <= 1;
    @(posedge clk) osc <= 0;
    repeat (29) @(posedge clk);
    lreq <= 0;
    neg_en <= 0;
    @(posedge clk) osc <= 1;
    hreq <= 1;
    chk("slope top", slope, 8'h1D);
    @(posedge clk) osc <= 0;
    @(posedge clk);
    chk("slope", slope, 8'h00);
    repeat (8) @(posedge clk);
    hreq <= 0;
    repeat (3) @(posedge clk);
  endtask : period
  initial
  begin
    repeat (10) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    chk("reset", {lg, hg, flg, cbc, hic, clamp, srs}, 0);
    repeat (4) @(posedge clk);
    // Reverse threshold tracks half the reference
    repeat (4)
    begin
      ilim <= 8'(rnd());
      repeat (2) @(posedge clk);
      chk("nthr", nthr, ilim >> 1);
    end
    $display("threshold test done");
    v = 8'(rnd() >> 26) + 8'h10;
    ramp <= v;
    pos_en <= 1;
    lreq <= 1;
    wait_on(0, 1);
    wait_on(0, 0);
    chk("blank", w >= `BLANK_CYC && w <= `BLANK_CYC + 7, 1);
    chk("limit", {flg, cbc, hic}, 3'b111);
    lreq <= 0;
    pos_en <= 0;
    ramp <= 0;
    // High request stays low: the matched pulse comes anyway
    wait_on(1, 1);
    wait_on(1, 0);
    chk("match", w + 1 >= v && w <= v + 4, 1);
    repeat (2) @(posedge clk);
    chk("flag", flg, 0);
    $display("matching test done");
    period(1);
    repeat (5) period(0);
    period(1);
    chk("window", clamp, 0);
    period(1);
    chk("clamp", {clamp, srs}, 2'b11);
    $display("reverse test done");
    // A mid-run reset must release the sticky clamp
    rstn <= 0;
    repeat (2) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    chk("reset2", {clamp, srs, flg, lg, hg}, 0);
    $display("reset test done");
    report_and_stop();
  end
endmodule : test_half_bridge_current_limit_logic
